// ===== rtl/adc_ctrl_pkg.sv
package adc_ctrl_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int RESULT_W = 16;

    // register addresses
    localparam logic [7:0] ADDR_RESULT_LOW = 8'h50;
    localparam logic [7:0] ADDR_RESULT_HIGH = 8'h51;
    localparam logic [7:0] ADDR_CONV_CTRL = 8'h52;
    localparam logic [7:0] ADDR_BIAS_STAGE = 8'h53;
    localparam logic [7:0] ADDR_RATE_AMP2 = 8'h54;
    localparam logic [7:0] ADDR_AMP1_AMP3_GAIN = 8'h55;
    localparam logic [7:0] ADDR_AMP3_OFFSET = 8'h56;
    localparam logic [7:0] ADDR_INPUT_ACTIVITY = 8'h57;
    localparam logic [7:0] ADDR_MODE = 8'h70;

    // conversion_control fields
    localparam int START_BIT = 7;
    localparam int NELC_MSB = 6;
    localparam int NELC_LSB = 5;
    localparam int OSR_MSB = 4;
    localparam int OSR_LSB = 2;
    localparam int CONTINUOUS_SEL_BIT = 1;
    // bias_and_stage_enable fields
    localparam int CBIAS_MSB = 7;
    localparam int CBIAS_LSB = 6;
    localparam int ABIAS_MSB = 5;
    localparam int ABIAS_LSB = 4;
    localparam int STAGE_MSB = 3;
    localparam int STAGE_LSB = 0;
    // rate_and_second_amp fields
    localparam int RATE_MSB = 7;
    localparam int RATE_LSB = 6;
    localparam int A2GAIN_MSB = 5;
    localparam int A2GAIN_LSB = 4;
    localparam int A2OFS_MSB = 3;
    localparam int A2OFS_LSB = 0;
    // first_third_amp_gain / third_amp_offset fields
    localparam int A1GAIN_BIT = 7;
    localparam int A3_MSB = 6;
    localparam int A3_LSB = 0;
    // input_and_activity fields
    localparam int BUSY_BIT = 7;
    localparam int DEF_BIT = 6;
    localparam int CHAN_MSB = 5;
    localparam int CHAN_LSB = 1;
    localparam int REFSEL_BIT = 0;
    // chip_operating_mode fields
    localparam int SETTLED_BIT = 7;
    localparam int RUNNING_BIT = 6;
    localparam int CHOP_MSB = 5;
    localparam int CHOP_LSB = 4;
    localparam int FRUN_BIT = 3;
    localparam int FSTOP_BIT = 2;
    localparam int REFOUT_BIT = 1;
    localparam int REFIN_BIT = 0;

    // reset values
    localparam logic [7:0] RESULT_RST = 8'h00;
    localparam logic [1:0] NELC_RST = 2'h1;
    localparam logic [2:0] OSR_RST = 3'h2;
    localparam logic CONTINUOUS_SEL_RST = 1'b0;
    localparam logic [1:0] CBIAS_RST = 2'h3;
    localparam logic [1:0] ABIAS_RST = 2'h3;
    localparam logic [3:0] STAGE_RST = 4'h0;
    localparam logic [1:0] RATE_RST = 2'h0;
    localparam logic [1:0] A2GAIN_RST = 2'h0;
    localparam logic [3:0] A2OFS_RST = 4'h0;
    localparam logic A1GAIN_RST = 1'b0;
    localparam logic [6:0] A3GAIN_RST = 7'h0C;
    localparam logic [6:0] A3OFS_RST = 7'h00;
    localparam logic DEF_RST = 1'b0;
    localparam logic [4:0] CHAN_RST = 5'h00;
    localparam logic REFSEL_RST = 1'b0;
    localparam logic SETTLED_RST = 1'b1;
    localparam logic FRUN_RST = 1'b0;
    localparam logic FSTOP_RST = 1'b1;
    localparam logic REFOUT_RST = 1'b0;
    localparam logic REFIN_RST = 1'b0;
    localparam logic [7:0] READ_NONE = 8'h00;

    typedef enum logic [1:0] {
        CHOP_HOLD_LOW = 2'b00,
        CHOP_HOLD_HIGH = 2'b01,
        CHOP_FULL_RATE = 2'b10,
        CHOP_HALF_RATE = 2'b11
    } chop_mode_t;

    localparam chop_mode_t CHOP_RST = CHOP_HOLD_LOW;

    typedef enum logic [0:0] {
        CONV_IDLE = 1'b0,
        CONV_RUN = 1'b1
    } conv_state_t;

endpackage

// ===== rtl/chop_gen.sv
`timescale 1ns/10ps
`default_nettype none

module chop_gen
    import adc_ctrl_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire adc_ctrl_pkg::chop_mode_t mode,
    input wire logic conv_launch,
    input wire logic elem_done,
    output logic chop_state
);

    logic chop_reg;
    logic chop_next;
    logic phase_reg;
    logic phase_next;

    // toggling restarts from low at every launch
    always_comb begin
        chop_next = chop_reg;
        phase_next = phase_reg;
        case (mode)
            CHOP_HOLD_LOW: begin
                chop_next = 1'b0;
                phase_next = 1'b0;
            end
            CHOP_HOLD_HIGH: begin
                chop_next = 1'b1;
                phase_next = 1'b0;
            end
            CHOP_FULL_RATE: begin
                phase_next = 1'b0;
                if (conv_launch) begin
                    chop_next = 1'b0;
                end else if (elem_done) begin
                    chop_next = ~chop_reg;
                end
            end
            CHOP_HALF_RATE: begin
                if (conv_launch) begin
                    chop_next = 1'b0;
                    phase_next = 1'b0;
                end else if (elem_done) begin
                    phase_next = ~phase_reg;
                    chop_next = chop_reg ^ phase_reg;
                end
            end
            default: begin
                chop_next = 1'b0;
                phase_next = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            chop_reg <= 1'b0;
            phase_reg <= 1'b0;
        end else begin
            chop_reg <= chop_next;
            phase_reg <= phase_next;
        end
    end

    assign chop_state = chop_reg;

endmodule

`default_nettype wire

// ===== rtl/adc_control_and_mode_regs.sv
`timescale 1ns/10ps
`default_nettype none

module adc_control_and_mode_regs (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic [adc_ctrl_pkg::ADDR_W-1:0] REG_ADDR,
    input wire logic [adc_ctrl_pkg::DATA_W-1:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [adc_ctrl_pkg::DATA_W-1:0] REG_RDATA,
    input wire logic [adc_ctrl_pkg::RESULT_W-1:0] RESULT_DATA,
    input wire logic RESULT_VALID,
    input wire logic ELEM_DONE,
    output logic CONV_START,
    output logic CONV_BUSY,
    output logic [1:0] ELEM_CONV_COUNT,
    output logic [2:0] OVERSAMPLE_SEL,
    output logic CONTINUOUS_SEL,
    output logic [1:0] CONVERTER_BIAS_SEL,
    output logic [1:0] AMPLIFIER_BIAS_SEL,
    output logic [3:0] STAGE_ENABLE,
    output logic [1:0] SAMPLE_RATE_SEL,
    output logic [1:0] SECOND_AMP_GAIN,
    output logic [3:0] SECOND_AMP_OFFSET,
    output logic FIRST_AMP_GAIN,
    output logic [6:0] THIRD_AMP_GAIN,
    output logic [6:0] THIRD_AMP_OFFSET,
    output logic DEFAULT_CONFIG_SEL,
    output logic [4:0] INPUT_CHANNEL_SEL,
    output logic REFERENCE_SOURCE_SEL,
    output logic AMP_RESET,
    output logic CHOP_STATE,
    input wire logic SUPPLY_LOW,
    input wire logic PUMP_SETTLED,
    output logic PUMP_ENABLE,
    input wire logic PAD_A_DIRECTION,
    input wire logic PAD_A_OUTPUT_VALUE,
    input wire logic PAD_B_DIRECTION,
    input wire logic PAD_B_OUTPUT_VALUE,
    output logic MULTI_PAD_A_OUT,
    output logic MULTI_PAD_A_OE_N,
    output logic MULTI_PAD_B_OUT,
    output logic MULTI_PAD_B_OE_N,
    output logic REFERENCE_OUT_PAD_A,
    output logic REFERENCE_IN_PAD_B
);
    import adc_ctrl_pkg::*;

    // stored fields
    logic [7:0] result_low_reg;
    logic [7:0] result_high_reg;
    logic [1:0] elem_conv_count_reg;
    logic [2:0] oversample_sel_reg;
    logic continuous_sel_reg;
    logic [1:0] converter_bias_sel_reg;
    logic [1:0] amplifier_bias_sel_reg;
    logic [3:0] stage_enable_reg;
    logic [1:0] sample_rate_sel_reg;
    logic [1:0] second_amp_gain_reg;
    logic [3:0] second_amp_offset_reg;
    logic first_amp_gain_reg;
    logic [6:0] third_amp_gain_reg;
    logic [6:0] third_amp_offset_reg;
    logic default_config_sel_reg;
    logic [4:0] input_channel_sel_reg;
    logic reference_source_sel_reg;
    chop_mode_t chop_mode_reg;
    logic pump_force_run_reg;
    logic pump_force_stop_reg;
    logic reference_out_pad_a_reg;
    logic reference_in_pad_b_reg;

    // status and control state
    conv_state_t conv_state_reg;
    conv_state_t conv_state_next;
    logic conv_start_reg;
    logic conv_start_next;
    logic amp_reset_reg;
    logic pump_running_reg;
    logic [7:0] rdata_reg;
    logic supply_low_meta_reg;
    logic supply_low_sync_reg;
    logic settled_meta_reg;
    logic settled_sync_reg;
    logic pad_a_out_reg;
    logic pad_a_oe_n_reg;
    logic pad_b_out_reg;
    logic pad_b_oe_n_reg;

    // write decode
    wire wr_conv_ctrl = REG_WR && (REG_ADDR == ADDR_CONV_CTRL);
    wire wr_bias_stage = REG_WR && (REG_ADDR == ADDR_BIAS_STAGE);
    wire wr_rate_amp2 = REG_WR && (REG_ADDR == ADDR_RATE_AMP2);
    wire wr_amp_gain = REG_WR && (REG_ADDR == ADDR_AMP1_AMP3_GAIN);
    wire wr_amp3_ofs = REG_WR && (REG_ADDR == ADDR_AMP3_OFFSET);
    wire wr_input = REG_WR && (REG_ADDR == ADDR_INPUT_ACTIVITY);
    wire wr_mode = REG_WR && (REG_ADDR == ADDR_MODE);
    wire amp_cfg_write = wr_bias_stage | wr_rate_amp2 | wr_amp_gain | wr_amp3_ofs | wr_input;
    wire start_req = wr_conv_ctrl && REG_WDATA[START_BIT];
    wire busy = (conv_state_reg == CONV_RUN);

    // pump control: force-on beats force-off, else follow supply-low
    wire pump_run_next = pump_force_run_reg |
                         (~pump_force_stop_reg & supply_low_sync_reg);

    // pad drive: general-purpose value only when output and not routed
    wire pad_a_drive = PAD_A_DIRECTION & ~reference_out_pad_a_reg;
    wire pad_b_drive = PAD_B_DIRECTION & ~reference_in_pad_b_reg;

    // read images
    wire [7:0] img_conv_ctrl = {busy, elem_conv_count_reg, oversample_sel_reg,
                                continuous_sel_reg, 1'b0};
    wire [7:0] img_bias_stage = {converter_bias_sel_reg, amplifier_bias_sel_reg,
                                 stage_enable_reg};
    wire [7:0] img_rate_amp2 = {sample_rate_sel_reg, second_amp_gain_reg,
                                second_amp_offset_reg};
    wire [7:0] img_amp_gain = {first_amp_gain_reg, third_amp_gain_reg};
    wire [7:0] img_amp3_ofs = {1'b0, third_amp_offset_reg};
    wire [7:0] img_input = {busy, default_config_sel_reg, input_channel_sel_reg,
                            reference_source_sel_reg};
    wire [7:0] img_mode = {settled_sync_reg, pump_running_reg, chop_mode_reg,
                           pump_force_run_reg, pump_force_stop_reg,
                           reference_out_pad_a_reg, reference_in_pad_b_reg};

    wire [7:0] rd_mux =
        (REG_ADDR == ADDR_RESULT_LOW) ? result_low_reg :
        (REG_ADDR == ADDR_RESULT_HIGH) ? result_high_reg :
        (REG_ADDR == ADDR_CONV_CTRL) ? img_conv_ctrl :
        (REG_ADDR == ADDR_BIAS_STAGE) ? img_bias_stage :
        (REG_ADDR == ADDR_RATE_AMP2) ? img_rate_amp2 :
        (REG_ADDR == ADDR_AMP1_AMP3_GAIN) ? img_amp_gain :
        (REG_ADDR == ADDR_AMP3_OFFSET) ? img_amp3_ofs :
        (REG_ADDR == ADDR_INPUT_ACTIVITY) ? img_input :
        (REG_ADDR == ADDR_MODE) ? img_mode : READ_NONE;

    // conversion sequencer; a new trigger beats the end of a single shot
    always_comb begin
        conv_state_next = conv_state_reg;
        conv_start_next = 1'b0;
        case (conv_state_reg)
            CONV_IDLE: begin
                if (start_req) begin
                    conv_state_next = CONV_RUN;
                    conv_start_next = 1'b1;
                end
            end
            CONV_RUN: begin
                if (start_req) begin
                    conv_start_next = 1'b1;
                end else if (RESULT_VALID) begin
                    if (continuous_sel_reg) begin
                        conv_start_next = 1'b1;
                    end else begin
                        conv_state_next = CONV_IDLE;
                    end
                end
            end
            default: begin
                conv_state_next = CONV_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            conv_state_reg <= CONV_IDLE;
            conv_start_reg <= 1'b0;
        end else begin
            conv_state_reg <= conv_state_next;
            conv_start_reg <= conv_start_next;
        end
    end

    // result capture, both bytes in the same edge
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            result_low_reg <= RESULT_RST;
            result_high_reg <= RESULT_RST;
        end else if (RESULT_VALID && busy) begin
            result_low_reg <= RESULT_DATA[7:0];
            result_high_reg <= RESULT_DATA[15:8];
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            elem_conv_count_reg <= NELC_RST;
            oversample_sel_reg <= OSR_RST;
            continuous_sel_reg <= CONTINUOUS_SEL_RST;
        end else if (wr_conv_ctrl) begin
            elem_conv_count_reg <= REG_WDATA[NELC_MSB:NELC_LSB];
            oversample_sel_reg <= REG_WDATA[OSR_MSB:OSR_LSB];
            continuous_sel_reg <= REG_WDATA[CONTINUOUS_SEL_BIT];
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            converter_bias_sel_reg <= CBIAS_RST;
            amplifier_bias_sel_reg <= ABIAS_RST;
            stage_enable_reg <= STAGE_RST;
        end else if (wr_bias_stage) begin
            converter_bias_sel_reg <= REG_WDATA[CBIAS_MSB:CBIAS_LSB];
            amplifier_bias_sel_reg <= REG_WDATA[ABIAS_MSB:ABIAS_LSB];
            stage_enable_reg <= REG_WDATA[STAGE_MSB:STAGE_LSB];
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            sample_rate_sel_reg <= RATE_RST;
            second_amp_gain_reg <= A2GAIN_RST;
            second_amp_offset_reg <= A2OFS_RST;
        end else if (wr_rate_amp2) begin
            sample_rate_sel_reg <= REG_WDATA[RATE_MSB:RATE_LSB];
            second_amp_gain_reg <= REG_WDATA[A2GAIN_MSB:A2GAIN_LSB];
            second_amp_offset_reg <= REG_WDATA[A2OFS_MSB:A2OFS_LSB];
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            first_amp_gain_reg <= A1GAIN_RST;
            third_amp_gain_reg <= A3GAIN_RST;
        end else if (wr_amp_gain) begin
            first_amp_gain_reg <= REG_WDATA[A1GAIN_BIT];
            third_amp_gain_reg <= REG_WDATA[A3_MSB:A3_LSB];
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            third_amp_offset_reg <= A3OFS_RST;
        end else if (wr_amp3_ofs) begin
            third_amp_offset_reg <= REG_WDATA[A3_MSB:A3_LSB];
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            default_config_sel_reg <= DEF_RST;
            input_channel_sel_reg <= CHAN_RST;
            reference_source_sel_reg <= REFSEL_RST;
        end else if (wr_input) begin
            default_config_sel_reg <= REG_WDATA[DEF_BIT];
            input_channel_sel_reg <= REG_WDATA[CHAN_MSB:CHAN_LSB];
            reference_source_sel_reg <= REG_WDATA[REFSEL_BIT];
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            chop_mode_reg <= CHOP_RST;
            pump_force_run_reg <= FRUN_RST;
            pump_force_stop_reg <= FSTOP_RST;
            reference_out_pad_a_reg <= REFOUT_RST;
            reference_in_pad_b_reg <= REFIN_RST;
        end else if (wr_mode) begin
            chop_mode_reg <= chop_mode_t'(REG_WDATA[CHOP_MSB:CHOP_LSB]);
            pump_force_run_reg <= REG_WDATA[FRUN_BIT];
            pump_force_stop_reg <= REG_WDATA[FSTOP_BIT];
            reference_out_pad_a_reg <= REG_WDATA[REFOUT_BIT];
            reference_in_pad_b_reg <= REG_WDATA[REFIN_BIT];
        end
    end

    // pin inputs through two flops
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            supply_low_meta_reg <= 1'b0;
            supply_low_sync_reg <= 1'b0;
            settled_meta_reg <= SETTLED_RST;
            settled_sync_reg <= SETTLED_RST;
        end else begin
            supply_low_meta_reg <= SUPPLY_LOW;
            supply_low_sync_reg <= supply_low_meta_reg;
            settled_meta_reg <= PUMP_SETTLED;
            settled_sync_reg <= settled_meta_reg;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            pump_running_reg <= 1'b0;
            amp_reset_reg <= 1'b0;
            rdata_reg <= READ_NONE;
        end else begin
            pump_running_reg <= pump_run_next;
            amp_reset_reg <= amp_cfg_write;
            if (REG_RD) begin
                rdata_reg <= rd_mux;
            end
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            pad_a_out_reg <= 1'b0;
            pad_a_oe_n_reg <= 1'b1;
            pad_b_out_reg <= 1'b0;
            pad_b_oe_n_reg <= 1'b1;
        end else begin
            pad_a_out_reg <= pad_a_drive & PAD_A_OUTPUT_VALUE;
            pad_a_oe_n_reg <= ~pad_a_drive;
            pad_b_out_reg <= pad_b_drive & PAD_B_OUTPUT_VALUE;
            pad_b_oe_n_reg <= ~pad_b_drive;
        end
    end

    chop_gen chop_gen_i (
        .clk(CLK),
        .rst_n(RST_N),
        .mode(chop_mode_reg),
        .conv_launch(conv_start_reg),
        .elem_done(ELEM_DONE),
        .chop_state(CHOP_STATE)
    );

    assign REG_RDATA = rdata_reg;
    assign CONV_START = conv_start_reg;
    assign CONV_BUSY = busy;
    assign ELEM_CONV_COUNT = elem_conv_count_reg;
    assign OVERSAMPLE_SEL = oversample_sel_reg;
    assign CONTINUOUS_SEL = continuous_sel_reg;
    assign CONVERTER_BIAS_SEL = converter_bias_sel_reg;
    assign AMPLIFIER_BIAS_SEL = amplifier_bias_sel_reg;
    assign STAGE_ENABLE = stage_enable_reg;
    assign SAMPLE_RATE_SEL = sample_rate_sel_reg;
    assign SECOND_AMP_GAIN = second_amp_gain_reg;
    assign SECOND_AMP_OFFSET = second_amp_offset_reg;
    assign FIRST_AMP_GAIN = first_amp_gain_reg;
    assign THIRD_AMP_GAIN = third_amp_gain_reg;
    assign THIRD_AMP_OFFSET = third_amp_offset_reg;
    assign DEFAULT_CONFIG_SEL = default_config_sel_reg;
    assign INPUT_CHANNEL_SEL = input_channel_sel_reg;
    assign REFERENCE_SOURCE_SEL = reference_source_sel_reg;
    assign AMP_RESET = amp_reset_reg;
    assign PUMP_ENABLE = pump_running_reg;
    assign MULTI_PAD_A_OUT = pad_a_out_reg;
    assign MULTI_PAD_A_OE_N = pad_a_oe_n_reg;
    assign MULTI_PAD_B_OUT = pad_b_out_reg;
    assign MULTI_PAD_B_OE_N = pad_b_oe_n_reg;
    assign REFERENCE_OUT_PAD_A = reference_out_pad_a_reg;
    assign REFERENCE_IN_PAD_B = reference_in_pad_b_reg;

endmodule

`default_nettype wire

// ===== tb/adc_ctrl_sva.sv
`timescale 1ns/10ps
`default_nettype none
module adc_ctrl_sva (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [7:0] REG_RDATA,
    input wire logic RESULT_VALID,
    input wire logic CONV_START,
    input wire logic CONV_BUSY,
    input wire logic CONTINUOUS_SEL,
    input wire logic AMP_RESET,
    input wire logic PUMP_ENABLE
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_N);
    wire logic cfg = REG_WR && REG_ADDR >= 8'h53 && REG_ADDR <= 8'h57;
    wire logic trig = REG_WR && REG_ADDR == 8'h52 && REG_WDATA[7];
    a_start_launch: assert property (trig |=> CONV_START && CONV_BUSY)
        else $error("no launch after trigger");
    a_amp_reset_on: assert property (cfg |=> AMP_RESET)
        else $error("no amp reset after write");
    a_amp_reset_cause: assert property (AMP_RESET |-> $past(cfg))
        else $error("amp reset without write");
    a_busy_done: assert property (CONV_BUSY && RESULT_VALID && !CONTINUOUS_SEL && !trig |=> !CONV_BUSY)
        else $error("busy stuck after result");
    a_busy_cause: assert property ($rose(CONV_BUSY) |-> CONV_START)
        else $error("busy rose without launch");
    a_pump_flag: assert property (REG_RD && REG_ADDR == 8'h70 |=> REG_RDATA[6] == $past(PUMP_ENABLE))
        else $error("pump running bit wrong");
    a_busy_flag: assert property (REG_RD && REG_ADDR == 8'h57 |=> REG_RDATA[7] == $past(CONV_BUSY))
        else $error("activity bit wrong");
    a_unused_zero: assert property (REG_RD && REG_ADDR == 8'h52 |=> !REG_RDATA[0])
        else $error("unused bit set");
    c_launch: cover property (trig ##1 CONV_BUSY [*2]);
    c_result: cover property (CONV_BUSY && RESULT_VALID);
    c_amp: cover property (cfg ##1 AMP_RESET);
endmodule
bind adc_control_and_mode_regs adc_ctrl_sva adc_ctrl_sva_i (.CLK(CLK), .RST_N(RST_N),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_RDATA(REG_RDATA), .RESULT_VALID(RESULT_VALID), .CONV_START(CONV_START),
    .CONV_BUSY(CONV_BUSY), .CONTINUOUS_SEL(CONTINUOUS_SEL), .AMP_RESET(AMP_RESET),
    .PUMP_ENABLE(PUMP_ENABLE));
`default_nettype wire

// ===== tb/host_model.sv
`timescale 1ns/10ps
`default_nettype none
module host_model (
    input wire logic clk,
    input wire logic [7:0] rdata,
    output logic [7:0] addr,
    output logic [7:0] wdata,
    output logic wr,
    output logic rd
);
    initial {addr, wdata, wr, rd} = 18'h00000;
    task automatic xfer(input logic w, input logic [7:0] a, v, output logic [7:0] q);
        @(negedge clk);
        addr = a;
        wdata = v;
        wr = w;
        rd = !w;
        @(negedge clk);
        wr = 1'b0;
        rd = 1'b0;
        wdata = ~v;
        q = rdata;
    endtask
endmodule
`default_nettype wire

// ===== tb/adc_control_and_mode_regs_tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin mismatches++; \
    $display("BAD %s exp %h got %h", n, e, g); end end
module adc_control_and_mode_regs_tb;
    int mismatches = 0;
    int total_checks = 0;
    logic clk = 0, rst_n = 0, valid = 0, low = 0, settled = 1, wr, rd, busy, pump;
    logic elem = 0, pdir = 0, pval = 0, chop, pa, pao, pb, pbo, ampr;
    logic [7:0] adr, wd, rdat, q;
    logic [15:0] res = 16'h0000;
    logic [7:0] ad [10] = '{8'h50, 8'h51, 8'h52, 8'h53, 8'h54, 8'h55, 8'h56, 8'h57, 8'h60, 8'h70};
    logic [7:0] rv [10] = '{8'h00, 8'h00, 8'h28, 8'hF0, 8'h00, 8'h0C, 8'h00, 8'h00, 8'h00, 8'h84};
    logic [7:0] wv [10] = '{8'hFF, 8'hFF, 8'h7F, 8'h9F, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h3F};
    logic [7:0] ev [10] = '{8'h00, 8'h00, 8'h7E, 8'h9F, 8'hFF, 8'hFF, 8'h7F, 8'h7F, 8'h00, 8'hFF};
    always #20 clk = ~clk;
    host_model host_model_i (.clk(clk), .rdata(rdat), .addr(adr), .wdata(wd), .wr(wr), .rd(rd));
    adc_control_and_mode_regs adc_control_and_mode_regs_i (.CLK(clk), .RST_N(rst_n),
        .REG_ADDR(adr), .REG_WDATA(wd), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdat),
        .RESULT_DATA(res), .RESULT_VALID(valid), .ELEM_DONE(elem), .CONV_START(),
        .CONV_BUSY(busy), .ELEM_CONV_COUNT(), .OVERSAMPLE_SEL(), .CONTINUOUS_SEL(),
        .CONVERTER_BIAS_SEL(), .AMPLIFIER_BIAS_SEL(), .STAGE_ENABLE(), .SAMPLE_RATE_SEL(),
        .SECOND_AMP_GAIN(), .SECOND_AMP_OFFSET(), .FIRST_AMP_GAIN(), .THIRD_AMP_GAIN(),
        .THIRD_AMP_OFFSET(), .DEFAULT_CONFIG_SEL(), .INPUT_CHANNEL_SEL(),
        .REFERENCE_SOURCE_SEL(), .AMP_RESET(ampr), .CHOP_STATE(chop), .SUPPLY_LOW(low),
        .PUMP_SETTLED(settled), .PUMP_ENABLE(pump), .PAD_A_DIRECTION(pdir),
        .PAD_A_OUTPUT_VALUE(pval), .PAD_B_DIRECTION(pdir), .PAD_B_OUTPUT_VALUE(pval),
        .MULTI_PAD_A_OUT(pa), .MULTI_PAD_A_OE_N(pao), .MULTI_PAD_B_OUT(pb),
        .MULTI_PAD_B_OE_N(pbo),
        .REFERENCE_OUT_PAD_A(), .REFERENCE_IN_PAD_B());
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic pulse();
        valid = 1'b1;
        @(negedge clk);
        valid = 1'b0;
        @(negedge clk);
    endtask
    task automatic t_regs();
        for (int i = 0; i < 10; i++) begin
            host_model_i.xfer(1'b0, ad[i], 8'h00, q);
            `CHK("reset value", rv[i], q)
        end
        for (int i = 0; i < 10; i++) begin
            host_model_i.xfer(1'b1, ad[i], wv[i], q);
            host_model_i.xfer(1'b0, ad[i], 8'h00, q);
            `CHK("readback", ev[i], q)
        end
    endtask
    task automatic t_conv();
        repeat (16) @(negedge clk); // settle before the trigger
        host_model_i.xfer(1'b1, 8'h52, 8'hA8, q);
        `CHK("busy", 1'b1, busy)
        res = 16'hA55A;
        pulse();
        `CHK("busy end", 1'b0, busy)
        host_model_i.xfer(1'b0, 8'h50, 8'h00, q);
        `CHK("low byte", 8'h5A, q)
        host_model_i.xfer(1'b0, 8'h51, 8'h00, q);
        `CHK("high byte", 8'hA5, q)
        host_model_i.xfer(1'b1, 8'h52, 8'h82, q);
        pulse();
        `CHK("continuous", 1'b1, busy)
        host_model_i.xfer(1'b1, 8'h52, 8'h00, q);
        pulse();
        `CHK("stopped", 1'b0, busy)
    endtask
    task automatic t_pump();
        host_model_i.xfer(1'b1, 8'h70, 8'h00, q);
        low = 1'b1;
        repeat (4) @(negedge clk);
        `CHK("pump auto", 1'b1, pump)
        host_model_i.xfer(1'b1, 8'h70, 8'h04, q);
        @(negedge clk);
        `CHK("pump stopped", 1'b0, pump)
        host_model_i.xfer(1'b1, 8'h70, 8'h0C, q);
        @(negedge clk);
        `CHK("force wins", 1'b1, pump)
        settled = 1'b0;
        low = 1'b0;
        repeat (4) @(negedge clk);
        host_model_i.xfer(1'b0, 8'h70, 8'h00, q);
        `CHK("mode status", 8'h4C, q)
    endtask
    task automatic step();
        elem = 1'b1;
        @(negedge clk);
        elem = 1'b0;
        @(negedge clk);
    endtask
    task automatic t_misc();
        host_model_i.xfer(1'b1, 8'h54, 8'h00, q);
        `CHK("amp reset", 1'b1, ampr)
        @(negedge clk);
        `CHK("amp reset end", 1'b0, ampr)
        pdir = 1'b1;
        pval = 1'b1;
        host_model_i.xfer(1'b1, 8'h70, 8'h00, q);
        @(negedge clk);
        `CHK("pads gpio", 4'hA, {pa, pao, pb, pbo})
        host_model_i.xfer(1'b1, 8'h70, 8'h03, q);
        @(negedge clk);
        `CHK("pads routed", 4'h5, {pa, pao, pb, pbo})
        host_model_i.xfer(1'b1, 8'h70, 8'h20, q);
        step();
        `CHK("chop full", 1'b1, chop)
        host_model_i.xfer(1'b1, 8'h70, 8'h10, q);
        @(negedge clk);
        `CHK("chop high", 1'b1, chop)
        host_model_i.xfer(1'b1, 8'h70, 8'h30, q);
        step();
        `CHK("chop half 1", 1'b1, chop)
        step();
        `CHK("chop half 2", 1'b0, chop)
    endtask
    initial begin
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        t_regs();
        t_conv();
        t_pump();
        t_misc();
        give_verdict();
    end
    initial begin
        #400000;
        mismatches++;
        give_verdict();
    end
endmodule
`default_nettype wire
